// ===== logic/iscs_status.sv
// internal state change status register with read-to-clear query port
`timescale 1ns/1ps
module iscs_status
  import iscs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // internal event pulses, one cycle each, same clock
  input wire iscs_events_t events,
  // status query from the command parser
  input wire logic query,
  // answer to the query
  output iscs_resp_t resp_reg,
  // live view of the held bits
  output logic [15:0] status_reg
);
  // =====================================================================
  // event vector in register order
  logic [15:0] set_vec; // set pulses by bit position
  logic [15:0] held; // sticky bits
  logic [15:0] report_next; // value the query would return
  logic quiet_reg; // check helper: register known empty after a read

  always_comb
  begin
    set_vec = 16'h0000;
    set_vec[ISCS_BIT_ACQ_DONE] = events.acq_done;
    set_vec[ISCS_BIT_DUMP_DONE] = events.dump_done;
    set_vec[ISCS_BIT_RET_LOCAL] = events.ret_local;
    set_vec[ISCS_BIT_BLK_TIMEOUT] = events.blk_timeout;
    set_vec[ISCS_BIT_SEG_ACQ] = events.seg_acq;
    set_vec[ISCS_BIT_STORE_FULL] = events.store_full;
    set_vec[ISCS_BIT_MEDIA_SWAP] = events.media_swap;
    set_vec[ISCS_BIT_TRACE_D:ISCS_BIT_TRACE_A] = events.trace_done;
    set_vec[ISCS_BIT_PASS_FAIL] = events.pass_fail;
    set_vec[ISCS_BIT_TRIG_READY] = events.trig_ready;
  end

  // =====================================================================
  // sticky bits, one per position; unused positions never set
  genvar gi;
  generate
    for (gi = 0; gi < ISCS_WIDTH; gi++)
    begin : g_bit
      iscs_sticky_bit #(
        .RESET_VAL(ISCS_RESET[gi])
      ) u_bit (
        .clk(clk),
        .rst(rst),
        .set_pulse(set_vec[gi] & ISCS_REPORT_MASK[gi]),
        .clr_pulse(query),
        .bit_reg(held[gi])
      );
    end
  endgenerate

  // masked value; bits 5, 14, 15 and reserved events read zero
  assign report_next = held & ISCS_REPORT_MASK;

  // =====================================================================
  // query answer: captured value before clearing, valid for one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resp_reg <= '0;
    end
    else
    begin
      resp_reg.valid <= query;
      if (query)
      begin
        resp_reg.value <= report_next;
      end
    end
  end

  // live copy registered for the output
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_reg <= ISCS_RESET;
    end
    else
    begin
      status_reg <= ((query ? 16'h0000 : report_next) | set_vec) & ISCS_REPORT_MASK;
    end
  end

  // =====================================================================
  // check helper: a read has emptied the bits and no counted event came since
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      quiet_reg <= 1'b0; // nothing read yet
    end
    else if ((set_vec & ISCS_REPORT_MASK) != 16'h0000)
    begin
      quiet_reg <= 1'b0; // a counted event refills the register
    end
    else if (query)
    begin
      quiet_reg <= 1'b1; // read with no event: bits now all zero
    end
  end

  // =====================================================================
  // check sequences
  // completed acquisition pulse
  sequence s_acq_event;
    events.acq_done;
  endsequence

  // trigger ready pulse
  sequence s_trig_event;
    events.trig_ready;
  endsequence

  // two idle cycles on the query line, then a read
  sequence s_idle_then_read;
    (!query) [*2] ##1 query;
  endsequence

  // both reported bits held when a read is taken
  sequence s_read_both;
    held[ISCS_BIT_ACQ_DONE] && held[ISCS_BIT_TRIG_READY] && query;
  endsequence

  // =====================================================================
  // checks
  // read with no event leaves every bit clear
  a_read_clears: assert property (@(posedge clk) disable iff (rst)
    query && !(events.acq_done || events.trig_ready) |=> held == 16'h0000)
    else $error("status not cleared after read");

  // answer shows up on the edge after the query
  a_answer_next: assert property (@(posedge clk) disable iff (rst)
    query |=> resp_reg.valid)
    else $error("no answer after query");

  // answer strobe lasts one cycle per query
  a_answer_once: assert property (@(posedge clk) disable iff (rst)
    !query |=> !resp_reg.valid)
    else $error("answer without query");

  // returned value stays until the next read
  a_value_holds: assert property (@(posedge clk) disable iff (rst)
    !query |=> $stable(resp_reg.value))
    else $error("answer value changed without query");

  // acquisition bit survives until a read
  a_bit_sticks: assert property (@(posedge clk) disable iff (rst)
    held[ISCS_BIT_ACQ_DONE] && !query |=> held[ISCS_BIT_ACQ_DONE])
    else $error("sticky bit dropped without read");

  // trigger bit survives until a read
  a_trig_sticks: assert property (@(posedge clk) disable iff (rst)
    held[ISCS_BIT_TRIG_READY] && !query |=> held[ISCS_BIT_TRIG_READY])
    else $error("trigger bit dropped without read");

  // event in the clearing cycle is kept for the next read
  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    events.acq_done && query |=> held[ISCS_BIT_ACQ_DONE])
    else $error("event lost in read cycle");

  // live view equals the held reported bits
  a_live_view: assert property (@(posedge clk) disable iff (rst)
    status_reg == (held & ISCS_REPORT_MASK))
    else $error("live view differs from held bits");

  // nothing outside bits 0 and 13 is ever returned
  a_only_two_bits: assert property (@(posedge clk) disable iff (rst)
    resp_reg.valid |-> (resp_reg.value & ~ISCS_REPORT_MASK) == 16'h0000)
    else $error("unreported bit returned");

  // acquisition pulse shows in a later read
  a_acq_sets_bit: assert property (@(posedge clk) disable iff (rst)
    s_acq_event ##1 s_idle_then_read |=> resp_reg.value[ISCS_BIT_ACQ_DONE])
    else $error("acquisition not reported");

  // trigger ready pulse is recorded
  a_trig_sets_bit: assert property (@(posedge clk) disable iff (rst)
    s_trig_event |=> held[ISCS_BIT_TRIG_READY])
    else $error("trigger ready not recorded");

  // trigger ready pulse shows in a later read
  a_trig_reported: assert property (@(posedge clk) disable iff (rst)
    s_trig_event ##1 s_idle_then_read |=> resp_reg.value[ISCS_BIT_TRIG_READY])
    else $error("trigger ready not reported");

  // both events between reads give 8193
  a_both_accum: assert property (@(posedge clk) disable iff (rst)
    s_read_both |=> resp_reg.value == 16'h2001)
    else $error("accumulated value wrong");

  // repeat read with no event in between returns zero
  a_second_read_zero: assert property (@(posedge clk) disable iff (rst)
    query && quiet_reg |=> resp_reg.value == 16'h0000)
    else $error("repeat read not zero");

  // reserved event inputs never reach the register
  a_reserved_ignored: assert property (@(posedge clk) disable iff (rst)
    (held & ~ISCS_REPORT_MASK) == 16'h0000)
    else $error("reserved event recorded");

  // unused positions stay zero
  a_zero_bits: assert property (@(posedge clk) disable iff (rst)
    status_reg[15:14] == 2'b00 && status_reg[5] == 1'b0)
    else $error("always-zero bit set");

  // reset empties the register and the answer strobe
  a_reset_clears: assert property (@(posedge clk)
    rst |=> status_reg == ISCS_RESET && resp_reg.valid == 1'b0)
    else $error("reset did not clear");
endmodule

// ===== logic/iscs_pkg.sv
// package: bit layout, reset value and carrier types for the state change status register
package iscs_pkg;
  // =====================================================================
  // register layout
  localparam int ISCS_WIDTH = 16;
  localparam int ISCS_BIT_ACQ_DONE = 0;
  localparam int ISCS_BIT_DUMP_DONE = 1;
  localparam int ISCS_BIT_RET_LOCAL = 2;
  localparam int ISCS_BIT_BLK_TIMEOUT = 3;
  localparam int ISCS_BIT_SEG_ACQ = 4;
  localparam int ISCS_BIT_STORE_FULL = 6;
  localparam int ISCS_BIT_MEDIA_SWAP = 7;
  localparam int ISCS_BIT_TRACE_A = 8;
  localparam int ISCS_BIT_TRACE_D = 11;
  localparam int ISCS_BIT_PASS_FAIL = 12;
  localparam int ISCS_BIT_TRIG_READY = 13;
  localparam logic [15:0] ISCS_RESET = 16'h0000;
  // positions that may ever read as one
  localparam logic [15:0] ISCS_REPORT_MASK = 16'h2001;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic acq_done;
    logic dump_done;
    logic ret_local;
    logic blk_timeout;
    logic seg_acq;
    logic store_full;
    logic media_swap;
    logic [3:0] trace_done;
    logic pass_fail;
    logic trig_ready;
  } iscs_events_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } iscs_resp_t;
endpackage

// ===== logic/iscs_sticky_bit.sv
// one sticky event bit: set by an event pulse, cleared by a status read
`timescale 1ns/1ps
module iscs_sticky_bit
  import iscs_pkg::*;
#(
  // value taken at reset
  parameter logic RESET_VAL = 1'b0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic set_pulse,
  input wire logic clr_pulse,
  // state
  output logic bit_reg
);
  // =====================================================================
  // sticky flop; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bit_reg <= RESET_VAL;
    end
    else if (set_pulse)
    begin
      bit_reg <= 1'b1;
    end
    else if (clr_pulse)
    begin
      bit_reg <= 1'b0;
    end
  end
endmodule

// ===== verif/iscs_host.sv
// host side model: issues status queries and catches the answers
`timescale 1ns/1ps
module iscs_host
  import iscs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench request and result
  input wire logic ask,
  output logic [15:0] value_reg,
  output logic done_reg,
  // link to the device
  output logic query,
  input wire iscs_resp_t resp
);
  // ==========================================================
  // query pulse per request, answer latched on valid
  always_ff @(posedge clk)
  begin
    query <= ask & ~rst;
    done_reg <= resp.valid;
    // keep the answer until the next one
    if (resp.valid)
    begin
      value_reg <= resp.value;
    end
  end
endmodule

// ===== verif/internal_state_change_status_test.sv
// testbench for the state change status register
`timescale 1ns/1ps
module internal_state_change_status_test
  import iscs_pkg::*;
;
  logic clk = 0; // bench clock
  logic rst = 1; // sync reset
  logic ask = 0; // host request
  logic query; // host to device
  logic done_reg; // answer seen
  logic [15:0] value_reg; // answer value
  logic [15:0] status_reg; // live bits
  iscs_events_t events = '0; // event pulses
  iscs_resp_t resp_reg; // device answer
  int errors = 0;
  int samples_checked = 0;
  iscs_status uut (.clk(clk), .rst(rst), .events(events), .query(query),
    .resp_reg(resp_reg), .status_reg(status_reg));
  iscs_host host (.clk(clk), .rst(rst), .ask(ask), .value_reg(value_reg),
    .done_reg(done_reg), .query(query), .resp(resp_reg));
  // ==========================================================
  // clock
  initial
  begin
    forever #10 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  // one event pulse
  task automatic ev(input logic [12:0] e);
    @(posedge clk) #1 events = iscs_events_t'(e);
    @(posedge clk) #1 events = '0;
  endtask
  // one status read; e is pulsed into the edge that takes the query
  task automatic rd_ev(input logic [12:0] e, input logic [15:0] exp);
    int n;
    @(posedge clk) #1 ask = 1;
    @(posedge clk) #1 ask = 0;
    events = iscs_events_t'(e);
    @(posedge clk) #1 events = '0;
    n = 0;
    while (done_reg !== 1'b1 && n < 8)
    begin
      @(posedge clk) #1;
      n++;
    end
    chk({15'h0, done_reg}, 16'h0001);
    chk(value_reg, exp);
  endtask
  // plain status read with no event
  task automatic rd(input logic [15:0] exp);
    rd_ev(13'h0000, exp);
  endtask
  // verdict
  task automatic test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog
  initial
  begin
    #20000;
    errors++;
    test_done;
  end
  // tests
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    rd(16'h0000);
    ev(13'h1000);
    chk(status_reg, 16'h0001);
    repeat (5) @(posedge clk);
    #1;
    chk(status_reg, 16'h0001);
    ev(13'h0001);
    rd(16'h2001);
    rd(16'h0000);
    chk(status_reg, 16'h0000);
    ev(13'h0001);
    rd(16'h2000);
    ev(13'h0ffe);
    chk(status_reg, 16'h0000);
    rd(16'h0000);
    rd_ev(13'h1000, 16'h0000);
    rd(16'h0001);
    ev(13'h1001);
    rd(16'h2001);
    ev(13'h1001);
    #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    chk(status_reg, 16'h0000);
    rd(16'h0000);
    test_done;
  end
endmodule
